/* src/asc_cfg.svh */
// Timing and width constants for the asynchronous memory controller
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
`define ASC_CLK_PERIOD_NS 10
`define ASC_ADDR_W 17
`define ASC_DATA_W 8
`define ASC_TRC_NS 10
`define ASC_TACS_NS 10
`define ASC_TWP_NS 7
`define ASC_TCW_NS 7
`define ASC_TWHZ_NS 5
`define ASC_TDW_NS 5
`define ASC_TOHZ_NS 5
`define ASC_CEIL(t) (((t) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_RD_CYC (`ASC_CEIL(`ASC_TACS_NS) + 1)
`define ASC_WP_PLAIN_CYC `ASC_CEIL(`ASC_TWP_NS)
`define ASC_WP_OE_CYC `ASC_CEIL(`ASC_TWHZ_NS + `ASC_TDW_NS)
`define ASC_WHZ_CYC `ASC_CEIL(`ASC_TWHZ_NS)
`define ASC_TURN_CYC `ASC_CEIL(`ASC_TOHZ_NS)
`endif

/* src/asc_cnt.sv */
// Down counter that pulses when a loaded cycle count has run out
`default_nettype none
module asc_cnt
(
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire asc_pkg::asc_cnt_t value,
	output logic done
);
	import asc_pkg::*;
	typedef struct packed {
		asc_cnt_t cnt;
		logic done;
	} asc_cnt_s;
	asc_cnt_s st, next_st;
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (load) begin
			next_st.cnt = value;
		end else if (st.cnt != 8'h00) begin
			next_st.cnt = st.cnt - 8'h01;
			next_st.done = (st.cnt == 8'h01);
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign done = st.done;
endmodule
`default_nettype wire

/* src/asc_ctrl.sv */
// Controller that runs read and write cycles on an asynchronous byte SRAM
`include "asc_cfg.svh"
`default_nettype none
module asc_ctrl
#(
	parameter int AW = `ASC_ADDR_W,
	parameter int DW = `ASC_DATA_W
) (
	// Request side, from logic on the same clock
	input wire logic CLK,
	input wire logic RST,
	input wire logic REQ,
	input wire logic REQ_WRITE,
	input wire logic REQ_OE_LOW,
	input wire logic [AW-1:0] REQ_ADDR,
	input wire logic [DW-1:0] REQ_WDATA,
	output logic BUSY,
	output logic DONE,
	output logic [DW-1:0] RDATA,

	// Memory pins; every strobe is active low
	output logic [AW-1:0] MEM_A,
	output asc_pkg::asc_strobe_s MEM_STB,
	input wire logic [DW-1:0] MEM_DQ_IN,
	output logic [DW-1:0] MEM_DQ_OUT,
	output logic MEM_DQ_OE
);
	import asc_pkg::*;

	// Load values for the shared down counter; each phase lasts one clock cycle more
	// Two extra read cycles cover the data synchroniser
	localparam asc_cnt_t RD_CNT = 8'(`ASC_RD_CYC + 2);
	localparam asc_cnt_t TURN_CNT = 8'(`ASC_TURN_CYC);
	localparam asc_cnt_t WHZ_CNT = 8'(`ASC_WHZ_CYC);
	localparam asc_cnt_t SETUP_CNT = 8'(`ASC_CEIL(`ASC_TDW_NS));
	localparam asc_cnt_t PLAIN_CNT = 8'(`ASC_WP_PLAIN_CYC);

	// All strobes released: memory deselected, its outputs floating
	localparam asc_strobe_s STB_IDLE = '{
		cs_n: 1'b1,
		we_n: 1'b1,
		oe_n: 1'b1
	};

	// Cycle shapes, counted from the edge that takes the request:
	// read: select and output enable low for RD_CNT counts, data
	// taken from the synchroniser, then TURN_CNT counts so the
	// memory has let go of the bus before the next cycle;
	// write, output enable high: data out with the strobes at once;
	// write, output enable low: strobes first, data after WHZ_CNT
	// counts, held SETUP_CNT counts before the strobes rise.
	// Select and write strobe always rise on the same edge.

	typedef struct packed {
		// Sequencer
		asc_state_e state;
		logic oe_low;
		logic busy;
		logic done;
		logic [DW-1:0] rdata;
		// Memory side
		logic [AW-1:0] addr;
		asc_strobe_s stb;
		logic [DW-1:0] dq_out;
		logic dq_oe;
		// Synchroniser stages for the data pins
		logic [DW-1:0] dq_s1;
		logic [DW-1:0] dq_s2;
	} asc_ctrl_s;
	asc_ctrl_s st, next_st;

	// Idle after reset, with the bus released
	localparam asc_ctrl_s ST_RESET = '{
		state: ASC_IDLE,
		oe_low: 1'b0,
		busy: 1'b0,
		done: 1'b0,
		rdata: '0,
		addr: '0,
		stb: STB_IDLE,
		dq_out: '0,
		dq_oe: 1'b0,
		dq_s1: '0,
		dq_s2: '0
	};

	logic load;
	asc_cnt_t value;
	logic cnt_done;

	// One counter times every phase of a cycle
	asc_cnt u_cnt (
		.clk(CLK),
		.rst(RST),
		.load(load),
		.value(value),
		.done(cnt_done)
	);
	// Next state of the whole controller, registered below
	always_comb begin
		next_st = st;
		load = 1'b0;
		value = 8'h00;
		next_st.done = 1'b0;

		// Two flip-flops before anything reads the data pins
		next_st.dq_s1 = MEM_DQ_IN;
		next_st.dq_s2 = st.dq_s1;

		unique case (st.state)
		ASC_IDLE: begin
			if (REQ) begin
				// Address and select change together on the same edge
				next_st.addr = REQ_ADDR;
				next_st.busy = 1'b1;
				next_st.oe_low = REQ_OE_LOW;
				next_st.dq_out = REQ_WDATA;
				load = 1'b1;
				if (REQ_WRITE) begin
					// Write strobe falls with select, so outputs stay off
					next_st.stb.cs_n = 1'b0;
					next_st.stb.we_n = 1'b0;
					next_st.stb.oe_n = ~REQ_OE_LOW;
					if (REQ_OE_LOW) begin
						// Data waits until the memory drivers let go
						value = WHZ_CNT;
						next_st.state = ASC_WHZ;
					end else begin
						// Outputs are already disabled: drive at once
						next_st.dq_oe = 1'b1;
						value = PLAIN_CNT;
						next_st.state = ASC_WDAT;
					end
				end else begin
					// Read: write strobe stays high throughout
					next_st.stb.cs_n = 1'b0;
					next_st.stb.we_n = 1'b1;
					next_st.stb.oe_n = 1'b0;
					value = RD_CNT;
					next_st.state = ASC_READ;
				end
			end
		end

		ASC_READ: begin
			// Data taken from the second synchroniser stage
			if (cnt_done) begin
				next_st.rdata = st.dq_s2;
				next_st.stb = STB_IDLE;
				load = 1'b1;
				value = TURN_CNT;
				next_st.state = ASC_TURN;
			end
		end

		ASC_WHZ: begin
			// Memory drivers float before write data is placed
			if (cnt_done) begin
				next_st.dq_oe = 1'b1;
				load = 1'b1;
				value = SETUP_CNT;
				next_st.state = ASC_WDAT;
			end
		end

		ASC_WDAT: begin
			// Select held low for the whole pulse, ended together
			if (cnt_done) begin
				next_st.stb = STB_IDLE;
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.state = ASC_IDLE;
			end
		end

		ASC_TURN: begin
			// Memory outputs float before the next cycle may drive
			if (cnt_done) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.state = ASC_IDLE;
			end
		end
		endcase

		// Write data leaves the bus on the edge that ends the pulse
		if (st.state == ASC_WDAT && cnt_done) begin
			next_st.dq_oe = 1'b0;
		end
	end

	// Synchronous reset puts the bus back to idle
	always_ff @(posedge CLK) begin
		if (RST) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Every output comes straight from a register
	assign BUSY = st.busy;
	assign DONE = st.done;
	assign RDATA = st.rdata;

	assign MEM_A = st.addr;
	assign MEM_STB = st.stb;
	assign MEM_DQ_OUT = st.dq_out;
	assign MEM_DQ_OE = st.dq_oe;
endmodule
`default_nettype wire

/* src/asc_pkg.sv */
// Types shared by the asynchronous memory controller
`default_nettype none
package asc_pkg;
	typedef enum logic [4:0] {
		ASC_IDLE = 5'h01,
		ASC_READ = 5'h02,
		ASC_TURN = 5'h04,
		ASC_WHZ = 5'h08,
		ASC_WDAT = 5'h10
	} asc_state_e;
	typedef struct packed {
		logic cs_n;
		logic we_n;
		logic oe_n;
	} asc_strobe_s;
	typedef logic [7:0] asc_cnt_t;
endpackage
`default_nettype wire

/* verification/asc_ctrl_properties.sv */
// Pin protocol checks for asc_ctrl
`default_nettype none
module asc_chk
	import asc_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic REQ,
	input wire logic REQ_WRITE,
	input wire logic REQ_OE_LOW,
	input wire logic BUSY,
	input wire logic [16:0] MEM_A,
	input wire asc_pkg::asc_strobe_s MEM_STB,
	input wire logic MEM_DQ_OE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire go = REQ && !BUSY;
	chk_read_we_high:
	assert property (go && !REQ_WRITE |=> (!MEM_STB.cs_n && MEM_STB.we_n)[*5]
		##1 MEM_STB.cs_n) else $error("bad read strobes");
	chk_addr_stable:
	assert property (!MEM_STB.cs_n && !$past(MEM_STB.cs_n) |-> $stable(MEM_A))
		else $error("address moved");
	chk_oe_low_pulse:
	assert property (go && REQ_WRITE && REQ_OE_LOW |=> !MEM_STB.we_n[*4]
		##1 MEM_STB.we_n) else $error("short write pulse");
	chk_plain_pulse:
	assert property (go && REQ_WRITE && !REQ_OE_LOW |=> !MEM_STB.we_n[*2]
		##1 MEM_STB.we_n) else $error("bad write pulse");
	chk_no_early_data:
	assert property ($fell(MEM_STB.we_n) && !MEM_STB.oe_n |-> !MEM_DQ_OE)
		else $error("data during float");
	chk_data_after_float:
	assert property (go && REQ_WRITE && REQ_OE_LOW |=> !MEM_DQ_OE[*2]
		##1 MEM_DQ_OE[*2] ##1 !MEM_DQ_OE) else $error("data timing");
	chk_data_in_write:
	assert property (MEM_DQ_OE |-> !MEM_STB.we_n) else $error("stray data");
	chk_cs_covers:
	assert property (!MEM_STB.we_n |-> !MEM_STB.cs_n) else $error("cs high");
endmodule
bind asc_ctrl asc_chk i_chk (.CLK, .RST, .REQ, .REQ_WRITE, .REQ_OE_LOW,
	.BUSY, .MEM_A, .MEM_STB, .MEM_DQ_OE);
`default_nettype wire

/* verification/asc_ctrl_test.sv */
// Self-checking bench for asc_ctrl
`default_nettype none
module asc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 0, RST = 1, REQ = 0, REQ_WRITE = 0, REQ_OE_LOW = 0;
	logic [16:0] REQ_ADDR = '0, MEM_A;
	logic [7:0] REQ_WDATA = '0, RDATA, MEM_DQ_OUT, dq;
	asc_pkg::asc_strobe_s MEM_STB;
	logic BUSY, DONE, MEM_DQ_OE;
	int err_count = 0, cmp_count = 0;
	logic [31:0] lf;
	logic [8:0] q[$];
	always #5 CLK = ~CLK;
	asc_ctrl i_dut (.CLK, .RST, .REQ, .REQ_WRITE, .REQ_OE_LOW, .REQ_ADDR,
		.REQ_WDATA, .BUSY, .DONE, .RDATA, .MEM_A, .MEM_STB,
		.MEM_DQ_IN(dq), .MEM_DQ_OUT, .MEM_DQ_OE);
	asc_mem i_mem (.clk(CLK), .a(MEM_A), .stb(MEM_STB), .dq_out(MEM_DQ_OUT),
		.dq_oe(MEM_DQ_OE), .dq);
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic op(input logic w, o);
		int n;
		lf = nx(lf);
		REQ <= 1;
		REQ_WRITE <= w;
		REQ_OE_LOW <= o;
		REQ_ADDR <= lf[16:0];
		REQ_WDATA <= lf[24:17];
		q.push_back({!w, lf[24:17]});
		@(posedge CLK);
		REQ <= 0;
		for (n = 0; n < 20; n++) begin
			@(posedge CLK);
			if (DONE === 1'b1) break;
		end
		if (n == 20) begin
			err_count++;
			results();
		end
	endtask
	// Oldest note is popped at each finished access; only reads are compared
	always @(posedge CLK)
		if (DONE === 1'b1 && q.size() > 0) begin
			if (q[0][8]) chk("rdata", RDATA, q[0][7:0]);
			void'(q.pop_front());
		end
	initial begin
		repeat (2) @(posedge CLK);
		RST <= 0;
		@(posedge CLK);
		chk("strobes", {5'h00, MEM_STB}, 8'h07);
		lf = 32'h5CC7;
		for (int i = 0; i < 8; i++) op(1, i[0]);
		$display("write test done");
		lf = 32'h5CC7;
		for (int i = 0; i < 8; i++) op(0, 0);
		$display("read test done");
		repeat (2) @(posedge CLK);
		results();
	end
endmodule
`default_nettype wire

/* verification/asc_mem.sv */
// Byte memory model on the far side of the controller
`default_nettype none
module asc_mem
	import asc_pkg::*;
(
	input wire logic clk,
	input wire logic [16:0] a,
	input wire asc_pkg::asc_strobe_s stb,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	output logic [7:0] dq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:131071];
	logic [7:0] last = 8'h00;
	wire drv = !stb.cs_n && !stb.oe_n && stb.we_n;
	always @(posedge clk) begin
		if (!stb.cs_n && !stb.we_n) mem[a] <= dq;
		last <= dq;
	end
	// Released bus shows a changing pattern
	assign dq = dq_oe ? (drv ? 8'hXX : dq_out) : (drv ? mem[a] : ~last);
endmodule
`default_nettype wire
